// ==== vic_core.v ====
// vectored interrupt controller top
// Contract
// RULE1: all peripheral requests merge into one request output to the core.
// RULE2: table has 246 source slots; slots without a source are reserved.
// RULE3: up to eight exception and software trap sources besides peripherals.
// RULE4: each source takes one of seven software-chosen priority levels.
// RULE5: equal-level pending sources resolve in fixed order, never rotating.
// RULE6: entry and return take constant cycle counts for any source.
// RULE7: software may raise any peripheral request, treated as hardware.
// RULE8: every source has its own vector entry.
// RULE9: primary table sits in program memory from word address 00004h.
// RULE10: primary table holds seven unmaskable trap vectors and 187 sources; here eight trap vectors at level 7, not offered when CPU_LEVEL is 7.
// RULE11: each entry is a 24-bit service routine start address.
// RULE12: lower table position wins; vector zero outranks all.
// RULE13: alternate table only with boot segment, enable bit, fuse at one.
// RULE14: alternate table starts at the first address of last boot page.
// RULE15: an enabled pending source wakes the device from sleep.
// RULE16: interrupt during power save is held until sleep entry completes; only WAKE is held, IRQ_TO_CORE still rises.
// RULE17: alternate table replaces primary base, same per-source offsets.
// RULE18: highest level pending enabled source wins, ties by order, index out.
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_core #(
	parameter NTRAP = `VIC_NUM_TRAP,
	parameter NIRQ = `VIC_NUM_IRQ,
	parameter NSRC = `VIC_NUM_SRC
) (
	input wire CORE_CLK,
	input wire RESETN,
	input wire [NIRQ-1:0] IRQ_HW,
	input wire [NIRQ-1:0] IRQ_SW_SET,
	input wire [NIRQ-1:0] IRQ_CLR,
	input wire [NIRQ-1:0] IRQ_ENABLE,
	input wire [NIRQ*3-1:0] IRQ_LEVEL,
	input wire [NTRAP-1:0] TRAP_REQ,
	input wire [2:0] CPU_LEVEL,
	input wire ACK,
	input wire RETI,
	input wire BOOT_SEGMENT_DEFINED,
	input wire ALT_TABLE_ENABLE,
	input wire ALT_TABLE_CONFIG_FUSE,
	input wire [23:0] BOOT_LAST_PAGE_BASE,
	input wire POWER_SAVE_INSTRUCTION,
	input wire SLEEPING,
	output reg IRQ_TO_CORE,
	output reg [7:0] VECTOR_INDEX,
	output reg [23:0] VECTOR_ADDR,
	output reg [2:0] VECTOR_LEVEL,
	output reg ENTRY_DONE,
	output reg RETURN_DONE,
	output reg WAKE
);
	localparam NTOT = NTRAP + NIRQ;
	localparam S_IDLE = 3'b001;
	localparam S_ENTRY = 3'b010;
	localparam S_RET = 3'b100;
	localparam [2:0] TRAP_LVL = 3'h7;

	reg [NIRQ-1:0] pend_reg;
	reg [NIRQ-1:0] pend_next;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] cnt_reg;
	reg [3:0] cnt_next;
	reg [1:0] hold_reg;
	reg [1:0] hold_next;
	reg take_ack;
	reg entry_done_next;
	reg return_done_next;

	wire [NTOT-1:0] req;
	wire [NTOT*3-1:0] lvl;
	wire found;
	wire [7:0] pick_idx;
	wire [2:0] pick_lvl;

	wire alt_active;
	wire [23:0] base;
	wire [23:0] addr_next;
	wire any_enabled;
	wire in_idle;
	wire stay_idle;
	wire irq_next;
	wire wake_next;

	// traps first so they hold the lowest natural positions
	// traps are plain levels with no pending flag; the source keeps them up
	genvar g;
	generate
		for (g = 0; g < NTOT; g = g + 1) begin : g_src
			if (g < NTRAP) begin : g_trap
				assign req[g] = TRAP_REQ[g]; // see RULE3 see RULE10
				assign lvl[g*3 +: 3] = TRAP_LVL;
			end else begin : g_irq
				assign req[g] = pend_reg[g-NTRAP] & IRQ_ENABLE[g-NTRAP];
				assign lvl[g*3 +: 3] = IRQ_LEVEL[(g-NTRAP)*3 +: 3]; // see RULE4
			end
		end
	endgenerate

	// fixed order tie break, no rotation
	// a level 0 source is parked: pending but never offered
	vic_prio_pick #(
		.N(NTOT),
		.IW(8)
	) vic_prio_pick_inst (
		.req(req),
		.lvl(lvl),
		.found(found),
		.idx(pick_idx),
		.best(pick_lvl)
	); // see RULE5 see RULE12 see RULE18

	assign alt_active = BOOT_SEGMENT_DEFINED & ALT_TABLE_ENABLE & ALT_TABLE_CONFIG_FUSE; // see RULE13
	// boot page size is not fixed here, so the alternate base comes in
	assign base = alt_active ? BOOT_LAST_PAGE_BASE : `VIC_PRIMARY_BASE; // see RULE9 see RULE14
	assign addr_next = base + {16'h0000, pick_idx};
	assign any_enabled = |(pend_reg & IRQ_ENABLE) | (|TRAP_REQ);
	assign in_idle = (state_reg == S_IDLE);

	// one entry or return in flight, counted down to a done pulse
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		take_ack = 1'b0;
		entry_done_next = 1'b0;
		return_done_next = 1'b0;
		case (state_reg)
			S_IDLE: begin
				// ack wins over a return strobe in the same cycle
				if (ACK && IRQ_TO_CORE) begin
					state_next = S_ENTRY;
					cnt_next = `VIC_ENTRY_CYCLES - 4'h1;
					take_ack = 1'b1;
				end else if (RETI) begin
					state_next = S_RET;
					cnt_next = `VIC_RETURN_CYCLES - 4'h1;
				end
			end
			S_ENTRY: begin
				// latency independent of source
				if (cnt_reg == 4'h0) begin
					state_next = S_IDLE;
					entry_done_next = 1'b1; // see RULE6
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			S_RET: begin
				if (cnt_reg == 4'h0) begin
					state_next = S_IDLE;
					return_done_next = 1'b1; // see RULE6
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	// pending flags: set beats clear in the same cycle, sw set same as hw
	always @* begin
		pend_next = (pend_reg & ~IRQ_CLR) | IRQ_HW | IRQ_SW_SET; // see RULE7
		// the taken source drops unless it is raised again in this very cycle
		if (take_ack && (VECTOR_INDEX >= NTRAP)) begin
			pend_next[VECTOR_INDEX - NTRAP] = IRQ_HW[VECTOR_INDEX - NTRAP]
				| IRQ_SW_SET[VECTOR_INDEX - NTRAP];
		end
	end

	// hold off wake while the power save instruction completes
	always @* begin
		hold_next = hold_reg;
		if (POWER_SAVE_INSTRUCTION) begin
			hold_next = `VIC_WAKE_HOLD_CYCLES; // see RULE16
		end else if (hold_reg != 2'h0) begin
			hold_next = hold_reg - 2'h1;
		end
	end

	assign wake_next = SLEEPING && any_enabled && !POWER_SAVE_INSTRUCTION
		&& (hold_reg == 2'h0); // see RULE15 see RULE16
	// vectors move only while idle and staying idle, so they stand through entry and return
	assign stay_idle = in_idle && (state_next == S_IDLE);
	// request only above current core level, and never when the core cannot ack it
	assign irq_next = found && (pick_lvl > CPU_LEVEL) && stay_idle; // see RULE1

	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pend_reg <= {NIRQ{1'b0}};
			state_reg <= S_IDLE;
			cnt_reg <= 4'h0;
			hold_reg <= 2'h0;
		end else begin
			pend_reg <= pend_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			hold_reg <= hold_next;
		end
	end

	// every output straight from a flop
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			IRQ_TO_CORE <= 1'b0;
			VECTOR_INDEX <= 8'h00;
			VECTOR_ADDR <= 24'h00_0000;
			VECTOR_LEVEL <= 3'h0;
			ENTRY_DONE <= 1'b0;
			RETURN_DONE <= 1'b0;
			WAKE <= 1'b0;
		end else begin
			ENTRY_DONE <= entry_done_next;
			RETURN_DONE <= return_done_next;
			WAKE <= wake_next;
			IRQ_TO_CORE <= irq_next;
			if (stay_idle) begin
				VECTOR_INDEX <= pick_idx; // see RULE8 see RULE2
				VECTOR_LEVEL <= pick_lvl;
				// one 24-bit word per source, offset from the active base
				VECTOR_ADDR <= addr_next; // see RULE11 see RULE17
			end
		end
	end
endmodule

// ==== vic_consts.vh ====
// constants for the vectored interrupt controller
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH
`define VIC_NUM_SRC 246
`define VIC_NUM_TRAP 8
`define VIC_NUM_IRQ 187
`define VIC_NUM_NMI_TRAP 7
`define VIC_PRIO_W 3
`define VIC_VEC_W 24
`define VIC_IDX_W 8
`define VIC_PRIMARY_BASE 24'h00_0004
`define VIC_ENTRY_CYCLES 4'h4
`define VIC_RETURN_CYCLES 4'h3
`define VIC_WAKE_HOLD_CYCLES 2'h2
`endif

// ==== vic_prio_pick.v ====
// priority picker: highest level wins, lowest index breaks ties
`timescale 1ns/1ps
`include "vic_consts.vh"
module vic_prio_pick #(
	parameter N = 195,
	parameter IW = 8
) (
	input wire [N-1:0] req,
	input wire [N*3-1:0] lvl,
	output reg found,
	output reg [IW-1:0] idx,
	output reg [2:0] best
);
	integer i;
	always @* begin
		found = 1'b0;
		idx = {IW{1'b0}};
		best = 3'h0;
		// scan from high index down so a lower index overwrites on equal level
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req[i] && (lvl[i*3 +: 3] >= best) && (lvl[i*3 +: 3] != 3'h0)) begin
				found = 1'b1;
				idx = i[IW-1:0];
				best = lvl[i*3 +: 3];
			end
		end
	end
endmodule

// ==== vic_core_checker.sv ====
// port assertions for the interrupt controller
`timescale 1ns/1ps
module vic_core_checker (
	input logic CORE_CLK,
	input logic RESETN,
	input logic ACK,
	input logic RETI,
	input logic IRQ_TO_CORE,
	input logic [7:0] VECTOR_INDEX,
	input logic [2:0] VECTOR_LEVEL,
	input logic [2:0] CPU_LEVEL,
	input logic ENTRY_DONE,
	input logic RETURN_DONE,
	input logic WAKE,
	input logic SLEEPING,
	input logic POWER_SAVE_INSTRUCTION
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	property p_ent; ACK && IRQ_TO_CORE |-> ##5 ENTRY_DONE; endproperty
	a_ent: assert property (p_ent) else $error("entry late");
	property p_ret; RETI |-> ##4 RETURN_DONE; endproperty
	a_ret: assert property (p_ret) else $error("return late");
	property p_pls; ENTRY_DONE |=> !ENTRY_DONE; endproperty
	a_pls: assert property (p_pls) else $error("entry pulse long");
	property p_drp; ACK && IRQ_TO_CORE |=> !IRQ_TO_CORE; endproperty
	a_drp: assert property (p_drp) else $error("request kept");
	property p_lvl; IRQ_TO_CORE |-> VECTOR_LEVEL > $past(CPU_LEVEL); endproperty
	a_lvl: assert property (p_lvl) else $error("level low");
	property p_frz; ACK && IRQ_TO_CORE |=> $stable(VECTOR_INDEX) [*5]; endproperty
	a_frz: assert property (p_frz) else $error("vector moved");
	property p_trp; IRQ_TO_CORE && VECTOR_INDEX < 8'h08 |-> VECTOR_LEVEL == 3'h7; endproperty
	a_trp: assert property (p_trp) else $error("trap level");
	property p_wak; WAKE |-> $past(SLEEPING) && !$past(POWER_SAVE_INSTRUCTION)
		&& !$past(POWER_SAVE_INSTRUCTION, 2) && !$past(POWER_SAVE_INSTRUCTION, 3); endproperty
	a_wak: assert property (p_wak) else $error("wake early");
	cover property (ACK && IRQ_TO_CORE);
	cover property (WAKE);
	cover property (RETURN_DONE);
	cover property (IRQ_TO_CORE && VECTOR_INDEX < 8'h08);
endmodule
bind vic_core vic_core_checker vic_core_checker_inst (.CORE_CLK, .RESETN, .ACK, .RETI,
	.IRQ_TO_CORE, .VECTOR_INDEX, .VECTOR_LEVEL, .CPU_LEVEL, .ENTRY_DONE, .RETURN_DONE,
	.WAKE, .SLEEPING, .POWER_SAVE_INSTRUCTION);

// ==== vic_core_partner.sv ====
// core model: takes a request, then returns from service
`timescale 1ns/1ps
module vic_core_partner (
	input wire clk,
	input wire irq,
	input wire ed,
	input wire slow,
	output reg ack,
	output reg reti
);
	integer n;
	initial begin
		ack = 0;
		reti = 0;
		forever begin
			@(negedge clk);
			if (irq === 1'b1) begin
				if (slow) repeat (8) @(negedge clk);
				ack = 1;
				@(negedge clk);
				ack = 0;
				for (n = 0; n < 20 && ed !== 1'b1; n = n + 1) @(negedge clk);
				@(negedge clk);
				reti = 1;
				@(negedge clk);
				reti = 0;
			end
		end
	end
endmodule

// ==== tb_vic_core.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_vic_core;
	reg clk = 0, rst_n = 0, slp = 0, pws = 0, bsd = 0, ate = 0, fuse = 0, slow = 0;
	reg [3:0] hw = 4'h0, sw = 4'h0;
	reg [11:0] lv = 12'h1b3;
	reg [7:0] trap = 8'h00;
	wire irq, ed, rd, wk, ack, reti;
	wire [7:0] vi;
	wire [23:0] va;
	integer error_cnt = 0, num_checks = 0, i, j;
	initial forever #12.5 clk = ~clk;
	vic_core #(.NIRQ(4)) vic_core_inst (.CORE_CLK(clk), .RESETN(rst_n), .IRQ_HW(hw),
		.IRQ_SW_SET(sw), .IRQ_CLR(4'h0), .IRQ_ENABLE(4'hf), .IRQ_LEVEL(lv), .TRAP_REQ(trap),
		.CPU_LEVEL(3'h2), .ACK(ack), .RETI(reti), .BOOT_SEGMENT_DEFINED(bsd),
		.ALT_TABLE_ENABLE(ate), .ALT_TABLE_CONFIG_FUSE(fuse),
		.BOOT_LAST_PAGE_BASE(24'h00_1000), .POWER_SAVE_INSTRUCTION(pws), .SLEEPING(slp),
		.IRQ_TO_CORE(irq), .VECTOR_INDEX(vi), .VECTOR_ADDR(va), .VECTOR_LEVEL(),
		.ENTRY_DONE(ed), .RETURN_DONE(rd), .WAKE(wk));
	vic_core_partner vic_core_partner_inst (.clk(clk), .irq(irq), .ed(ed), .slow(slow),
		.ack(ack), .reti(reti));
	task stop_test(input integer f);
		error_cnt = error_cnt + f;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [8*4:1] nm, input [23:0] e, input [23:0] s);
		num_checks = num_checks + 1;
		if (s !== e) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	// drop level sources once seen, so the ack does not re-pend them
	task serve(input [7:0] ei, input [23:0] ea);
		for (i = 0; i < 50 && irq !== 1'b1; i = i + 1) @(negedge clk);
		if (i == 50) stop_test(1);
		hw = 4'h0;
		sw = 4'h0;
		trap = 8'h00;
		chk("indx", {16'h0000, ei}, {16'h0000, vi});
		chk("addr", ea, va);
		for (i = 0; i < 50 && rd !== 1'b1; i = i + 1) @(negedge clk);
		if (i == 50) stop_test(1);
	endtask
	task t_prio;
		hw = 4'hb;
		sw = 4'h4;
		serve(8'h09, 24'h00_000d);
		serve(8'h0a, 24'h00_000e);
		serve(8'h08, 24'h00_000c);
		repeat (5) @(negedge clk);
		chk("lvl0", 24'h00_0000, {23'h00_0000, irq});
	endtask
	task t_alt;
		for (j = 0; j < 8; j = j + 1) begin
			{bsd, ate, fuse} = j[2:0];
			trap = 8'h01 << j;
			serve(j[7:0], (j == 7) ? 24'h00_1007 : j[23:0] + 24'h00_0004);
		end
		{bsd, ate, fuse} = 3'h0;
	endtask
	task t_wake;
		slow = 1;
		slp = 1;
		pws = 1;
		hw = 4'h1;
		repeat (3) @(negedge clk);
		chk("wake", 24'h00_0000, {23'h00_0000, wk});
		pws = 0;
		for (i = 0; i < 8 && wk !== 1'b1; i = i + 1) @(negedge clk);
		chk("wake", 24'h00_0001, {23'h00_0000, wk});
		slp = 0;
		slow = 0;
		serve(8'h08, 24'h00_000c);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		t_prio;
		t_alt;
		t_wake;
		stop_test(0);
	end
endmodule
